// ---- hw/echo_pulse_timer.sv ----
`timescale 1ns/100ps
`default_nettype none

module echo_pulse_timer #(
   parameter int PULSE_CYCLES = 24800
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic trigger_in,
   output logic drive_low_out
);

   localparam int CW = $clog2(PULSE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

   logic [CW-1:0] count;
   logic active;
   logic [CW-1:0] next_count;
   logic next_active;

   // triggers inside a running pulse merge into it
   always_comb begin
      next_count = count;
      next_active = active;
      if (active) begin
         if (count == LAST) begin
            next_active = 1'b0;
         end else begin
            next_count = count + CW'(1);
         end
      end else if (enable_in && trigger_in) begin
         next_active = 1'b1;
         next_count = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count <= '0;
         active <= 1'b0;
      end else begin
         count <= next_count;
         active <= next_active;
      end
   end

   assign drive_low_out = active;

endmodule

`default_nettype wire

// ---- hw/ultrasonic_status_result_memory.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "usrm_defines.svh"

// How it works
// - reset loads every configuration cell from the nonvolatile image
// - echo pulse mode without advanced io reports echoes as 99.2 us lows
// - in echo pulse mode without advanced io, host low for 350 us during a measurement stops it
// - send measurement pulses at reverb end of direct measurements, then at each echo
// - echoes closer than 99.2 us merge into one pulse
// - long result index answers only with advanced io and width peak
// - flight time is 10 bits of 51.2 us, zero without echo
// - peak is 6 bit max magnitude, zero without echo
// - width is 6 bits of 12.8 us, zero without echo
// - index 15 write is command byte, read gives revision nibbles
// - noise flag set above threshold in window, cleared by any measurement
// - supply flag on undervoltage or overvoltage crossing during transmit
// - overvoltage during transmit stops transmit, measurement goes on
// - period flag set outside variation window, and after reset
// - direction flag set when measured period exceeds carrier period
// - decay flag set when ringdown shorter than monitor duration
// - timeout flag set when decay outlasts reverb timeout ticks
// - flags 1 to 5 change only on direct measurements
// - frames go LSB first; index 0 temperature, index 1 status
// - slope select picks 60 us or fast 20 us line edges
// - a configuration bit enables the internal line pull-up
// - command byte is write-only, index 15 reads revision only
module ultrasonic_status_result_memory
   import usrm_pkg::*;
#(
   parameter int ECHO_PULSE_CYCLES = `USRM_MIN_CYCLES(`USRM_ECHO_PULSE_NS),
   parameter int HOST_STOP_CYCLES = `USRM_MIN_CYCLES(`USRM_HOST_STOP_NS),
   parameter int DEBOUNCE_CYCLES = `USRM_MIN_CYCLES(`USRM_DEBOUNCE_NS),
   parameter int FINE_TICK_CYCLES = `USRM_MIN_CYCLES(`USRM_FINE_TICK_NS),
   parameter logic [3:0] FULL_MASK_REV = 4'h3, // arbitrary value
   parameter logic [3:0] METAL_TUNE_REV = 4'h2 // arbitrary value
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   // configuration memory
   input wire cfg_t EEPROM_CFG_IN,
   input wire logic CFG_WR_IN,
   input wire cfg_t CFG_IN,
   output cfg_t CFG_OUT,
   // index access from the line decoder
   input wire logic RD_REQ_IN,
   input wire logic WR_REQ_IN,
   input wire logic [3:0] INDEX_IN,
   input wire logic [7:0] WR_DATA_IN,
   input wire logic TX_SHIFT_IN,
   output frame_t FRAME_OUT,
   output logic RD_NONE_OUT,
   output logic TX_BIT_OUT,
   output logic [7:0] CMD_OUT,
   output logic CMD_STB_OUT,
   // measurement events from the sequencer and dsp
   input wire logic MEAS_START_IN,
   input wire logic MEAS_DIRECT_IN,
   input wire logic MEAS_END_IN,
   input wire logic TX_ACTIVE_IN,
   input wire logic REVERB_END_IN,
   input wire logic [10:0] REVERB_PER_IN,
   input wire logic ECHO_ACTIVE_IN,
   input wire logic [5:0] ECHO_MAG_IN,
   input wire logic NOISE_WINDOW_IN,
   input wire logic [7:0] NOISE_MAG_IN,
   input wire logic [7:0] TEMP_CODE_IN,
   // supply comparators
   input wire logic UNDERVOLT_IN,
   input wire logic OVERVOLT_IN,
   // control outputs
   output logic TX_STOP_OUT,
   output logic MEAS_STOP_OUT,
   output logic LINE_CMD_ARMED_OUT,
   output logic [7:0] STATUS_OUT,
   // io line
   input wire logic IO_LINE_IN,
   output logic IO_LINE_OUT,
   output logic IO_LINE_OE_OUT,
   output logic LINE_FAST_SLOPE_OUT,
   output logic LINE_PULLUP_OUT
);

   localparam int SW = $clog2(HOST_STOP_CYCLES + DEBOUNCE_CYCLES + 1);
   localparam int FW = $clog2(FINE_TICK_CYCLES + 1);

   // --------------------
   // pin synchronisers and tick dividers
   // --------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic line_high, undervolt, overvolt;
   logic [FW-1:0] fine_cnt;
   logic [1:0] coarse_cnt;
   logic fine_tick, coarse_tick;

   assign line_high = pin_sync[0];
   assign undervolt = pin_sync[1];
   assign overvolt = pin_sync[2];
   assign fine_tick = (fine_cnt == FW'(FINE_TICK_CYCLES - 1));
   assign coarse_tick = fine_tick &&
      (coarse_cnt == 2'(`USRM_COARSE_PER_FINE - 1));

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         pin_meta <= 3'h1;
         pin_sync <= 3'h1;
         fine_cnt <= '0;
         coarse_cnt <= 2'h0;
      end else begin
         pin_meta <= {OVERVOLT_IN, UNDERVOLT_IN, IO_LINE_IN};
         pin_sync <= pin_meta;
         fine_cnt <= fine_tick ? '0 : fine_cnt + FW'(1);
         coarse_cnt <= fine_tick ? coarse_cnt + 2'(1) : coarse_cnt;
      end
   end

   // --------------------
   // configuration memory and command byte
   // --------------------
   cfg_t cfg, next_cfg;
   logic [7:0] next_cmd;
   logic next_cmd_stb;

   always_comb begin
      next_cfg = CFG_WR_IN ? CFG_IN : cfg;
      next_cmd = CMD_OUT;
      next_cmd_stb = 1'b0;
      if (WR_REQ_IN && INDEX_IN == `USRM_IDX_CMD_REV) begin
         next_cmd = WR_DATA_IN;
         next_cmd_stb = 1'b1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         cfg <= EEPROM_CFG_IN;
         CMD_OUT <= 8'h00;
         CMD_STB_OUT <= 1'b0;
      end else begin
         cfg <= next_cfg;
         CMD_OUT <= next_cmd;
         CMD_STB_OUT <= next_cmd_stb;
      end
   end

   assign CFG_OUT = cfg;
   assign LINE_FAST_SLOPE_OUT = cfg.line_slope_select;
   assign LINE_PULLUP_OUT = cfg.line_pullup_enable;

   // --------------------
   // measurement tracking and status flags
   // --------------------
   logic meas_active, meas_direct, tx_prev, ov_at_tx, in_decay;
   logic [7:0] decay_cnt;
   logic [7:0] status;
   logic [10:0] ringdown_period;
   logic next_meas_active, next_meas_direct, next_ov_at_tx, next_in_decay;
   logic [7:0] next_decay_cnt, next_status;
   logic [10:0] next_ringdown_period;
   logic [11:0] period_diff;
   logic tx_rise, tx_fall, direct_now;

   assign tx_rise = TX_ACTIVE_IN && !tx_prev;
   assign tx_fall = !TX_ACTIVE_IN && tx_prev;
   assign direct_now = meas_active && meas_direct;
   assign period_diff = (REVERB_PER_IN > cfg.carrier_period) ?
      {1'b0, REVERB_PER_IN - cfg.carrier_period} :
      {1'b0, cfg.carrier_period - REVERB_PER_IN};

   always_comb begin
      next_meas_active = meas_active;
      next_meas_direct = meas_direct;
      next_ov_at_tx = ov_at_tx;
      next_in_decay = in_decay;
      next_decay_cnt = decay_cnt;
      next_ringdown_period = ringdown_period;
      next_status = status;
      if (MEAS_START_IN) begin
         next_meas_active = 1'b1;
         next_meas_direct = MEAS_DIRECT_IN;
         next_in_decay = 1'b0;
         next_status[`USRM_ST_NOISE] = 1'b0;
         if (MEAS_DIRECT_IN) begin
            next_status[`USRM_ST_REVERB_TOUT:`USRM_ST_SUPPLY] = 5'h00;
         end
      end else if (MEAS_END_IN || MEAS_STOP_OUT) begin
         next_meas_active = 1'b0;
         next_in_decay = 1'b0;
      end
      if (NOISE_WINDOW_IN && NOISE_MAG_IN > cfg.noise_threshold) begin
         next_status[`USRM_ST_NOISE] = 1'b1;
      end
      if (direct_now) begin
         if (tx_rise) begin
            next_ov_at_tx = overvolt;
         end
         if (TX_ACTIVE_IN && (undervolt || (overvolt && !ov_at_tx &&
               !(tx_rise && overvolt)))) begin
            next_status[`USRM_ST_SUPPLY] = 1'b1;
         end
         if (tx_fall) begin
            next_in_decay = 1'b1;
            next_decay_cnt = 8'h00;
         end else if (in_decay && coarse_tick && decay_cnt != 8'hFF) begin
            next_decay_cnt = decay_cnt + 8'h01;
         end
         if (in_decay && decay_cnt > {2'b00, cfg.reverb_timeout}) begin
            next_status[`USRM_ST_REVERB_TOUT] = 1'b1;
         end
         if (REVERB_END_IN && in_decay) begin
            next_in_decay = 1'b0;
            next_ringdown_period = REVERB_PER_IN;
            if (period_diff > {4'h0, cfg.period_variation_limit}) begin
               next_status[`USRM_ST_PERIOD_UPD] = 1'b1;
            end
            if (REVERB_PER_IN > cfg.carrier_period) begin
               next_status[`USRM_ST_PERIOD_DIR] = 1'b1;
            end
            if (decay_cnt < cfg.ringdown_monitor_duration) begin
               next_status[`USRM_ST_DECAY_SHORT] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         meas_active <= 1'b0;
         meas_direct <= 1'b0;
         tx_prev <= 1'b0;
         ov_at_tx <= 1'b0;
         in_decay <= 1'b0;
         decay_cnt <= 8'h00;
         ringdown_period <= 11'h000;
         status <= `USRM_STATUS_RESET;
      end else begin
         meas_active <= next_meas_active;
         meas_direct <= next_meas_direct;
         tx_prev <= TX_ACTIVE_IN;
         ov_at_tx <= next_ov_at_tx;
         in_decay <= next_in_decay;
         decay_cnt <= next_decay_cnt;
         ringdown_period <= next_ringdown_period;
         status <= next_status;
      end
   end

   // transmit cut on overvoltage, rest of measurement unaffected
   assign TX_STOP_OUT = meas_active && TX_ACTIVE_IN && overvolt;
   assign STATUS_OUT = status;

   // --------------------
   // first echo results
   // --------------------
   long_res_t lres, next_lres;
   logic echo_prev, first_seen, first_open;
   logic next_first_seen, next_first_open;
   logic [9:0] flight_cnt, next_flight_cnt;
   logic echo_rise;

   assign echo_rise = ECHO_ACTIVE_IN && !echo_prev && meas_active;

   always_comb begin
      next_lres = lres;
      next_first_seen = first_seen;
      next_first_open = first_open;
      next_flight_cnt = flight_cnt;
      if (MEAS_START_IN) begin
         next_lres = '0;
         next_first_seen = 1'b0;
         next_first_open = 1'b0;
         next_flight_cnt = 10'h000;
      end else if (meas_active) begin
         if (coarse_tick && flight_cnt != 10'h3FF) begin
            next_flight_cnt = flight_cnt + 10'h001;
         end
         if (echo_rise && !first_seen) begin
            next_first_seen = 1'b1;
            next_first_open = 1'b1;
            next_lres.first_echo_flight_time = flight_cnt;
         end
         if (first_open) begin
            if (!ECHO_ACTIVE_IN) begin
               next_first_open = 1'b0;
            end else begin
               if (ECHO_MAG_IN > lres.first_echo_peak) begin
                  next_lres.first_echo_peak = ECHO_MAG_IN;
               end
               if (fine_tick && lres.first_echo_width != 6'h3F) begin
                  next_lres.first_echo_width =
                     lres.first_echo_width + 6'h01;
               end
            end
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         lres <= '0;
         echo_prev <= 1'b0;
         first_seen <= 1'b0;
         first_open <= 1'b0;
         flight_cnt <= 10'h000;
      end else begin
         lres <= next_lres;
         echo_prev <= ECHO_ACTIVE_IN;
         first_seen <= next_first_seen;
         first_open <= next_first_open;
         flight_cnt <= next_flight_cnt;
      end
   end

   // --------------------
   // echo pulse reporting and host stop
   // --------------------
   logic pulse_mode, pulse_low;
   stop_state_t stop_state, next_stop_state;
   logic [SW-1:0] stop_cnt, next_stop_cnt;
   logic next_meas_stop;

   assign pulse_mode = cfg.echo_pulse_mode_enable &&
      !cfg.advanced_io_mode_enable;

   echo_pulse_timer #(
      .PULSE_CYCLES(ECHO_PULSE_CYCLES)
   ) u_pulse (
      .clk_in(CLK_IN),
      .reset_in(RESET_IN),
      .enable_in(pulse_mode && meas_active),
      .trigger_in(echo_rise ||
         (meas_direct && REVERB_END_IN)),
      .drive_low_out(pulse_low)
   );

   assign IO_LINE_OUT = 1'b0;
   assign IO_LINE_OE_OUT = pulse_low;

   // own pulses also pull the line low, so they never count as a stop
   always_comb begin
      next_stop_state = stop_state;
      next_stop_cnt = stop_cnt;
      next_meas_stop = 1'b0;
      unique case (stop_state)
         STOP_IDLE: begin
            next_stop_cnt = '0;
            if (pulse_mode && meas_active && !line_high && !pulse_low) begin
               next_stop_state = STOP_COUNT;
            end
         end
         STOP_COUNT: begin
            if (line_high || pulse_low || !meas_active) begin
               next_stop_state = STOP_IDLE;
            end else if (stop_cnt == SW'(HOST_STOP_CYCLES - 2)) begin
               next_meas_stop = 1'b1;
               next_stop_state = STOP_RELEASE;
               next_stop_cnt = '0;
            end else begin
               next_stop_cnt = stop_cnt + SW'(1);
            end
         end
         STOP_RELEASE: begin
            if (!line_high) begin
               next_stop_cnt = '0;
            end else if (stop_cnt == SW'(DEBOUNCE_CYCLES - 1)) begin
               next_stop_state = STOP_IDLE;
            end else begin
               next_stop_cnt = stop_cnt + SW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         stop_state <= STOP_IDLE;
         stop_cnt <= '0;
         MEAS_STOP_OUT <= 1'b0;
      end else begin
         stop_state <= next_stop_state;
         stop_cnt <= next_stop_cnt;
         MEAS_STOP_OUT <= next_meas_stop;
      end
   end

   assign LINE_CMD_ARMED_OUT = (stop_state != STOP_RELEASE);

   // --------------------
   // index read frames, sent LSB first
   // --------------------
   frame_t next_frame;
   logic [31:0] shift, next_shift;
   logic next_none;

   always_comb begin
      next_frame = '0;
      next_none = 1'b0;
      next_shift = TX_SHIFT_IN ? {1'b0, shift[31:1]} : shift;
      if (RD_REQ_IN) begin
         next_frame.valid = 1'b1;
         unique case (INDEX_IN)
            `USRM_IDX_TEMPERATURE: begin
               next_frame.bits = `USRM_LEN_TEMPERATURE;
               next_frame.data = {24'h000000, TEMP_CODE_IN};
            end
            `USRM_IDX_STATUS: begin
               next_frame.bits = `USRM_LEN_STATUS;
               next_frame.data = {13'h0000, ringdown_period,
                  status};
            end
            `USRM_IDX_LONG_RESULT: begin
               if (cfg.advanced_io_mode_enable && cfg.width_peak_enable) begin
                  next_frame.bits = `USRM_LEN_LONG;
                  next_frame.data = {2'b00, lres, status};
               end else begin
                  next_frame.valid = 1'b0;
                  next_none = 1'b1;
               end
            end
            `USRM_IDX_CMD_REV: begin
               next_frame.bits = `USRM_LEN_CMD_REV;
               next_frame.data = {24'h000000, FULL_MASK_REV,
                  METAL_TUNE_REV};
            end
            default: begin
               next_frame.valid = 1'b0;
               next_none = 1'b1;
            end
         endcase
         if (next_frame.valid) begin
            next_shift = next_frame.data;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         FRAME_OUT <= '0;
         RD_NONE_OUT <= 1'b0;
         shift <= 32'h00000000;
      end else begin
         FRAME_OUT <= next_frame;
         RD_NONE_OUT <= next_none;
         shift <= next_shift;
      end
   end

   assign TX_BIT_OUT = shift[0];

endmodule

`default_nettype wire

// ---- hw/usrm_defines.svh ----
`ifndef USRM_DEFINES_SVH
`define USRM_DEFINES_SVH

// --------------------
// timing, indexes, status bits, frame lengths
// --------------------
`define USRM_CLK_MHZ 250
`define USRM_ECHO_PULSE_NS 99200
`define USRM_HOST_STOP_NS 350000
`define USRM_DEBOUNCE_NS 10000
`define USRM_FINE_TICK_NS 12800
`define USRM_COARSE_PER_FINE 4
// least times round up to whole cycles
`define USRM_MIN_CYCLES(ns) (((ns) * `USRM_CLK_MHZ + 999) / 1000)
`define USRM_IDX_TEMPERATURE 4'h0
`define USRM_IDX_STATUS 4'h1
`define USRM_IDX_LONG_RESULT 4'hE
`define USRM_IDX_CMD_REV 4'hF
`define USRM_ST_NOISE 0
`define USRM_ST_SUPPLY 1
`define USRM_ST_PERIOD_UPD 2
`define USRM_ST_PERIOD_DIR 3
`define USRM_ST_DECAY_SHORT 4
`define USRM_ST_REVERB_TOUT 5
`define USRM_LEN_TEMPERATURE 6'd8
`define USRM_LEN_STATUS 6'd19
`define USRM_LEN_LONG 6'd30
`define USRM_LEN_CMD_REV 6'd8
`define USRM_STATUS_RESET 8'h04

`endif

// ---- hw/usrm_pkg.sv ----
package usrm_pkg;

   // configuration cells preloaded from nonvolatile storage
   typedef struct packed {
      logic echo_pulse_mode_enable;
      logic advanced_io_mode_enable;
      logic width_peak_enable;
      logic line_slope_select;
      logic line_pullup_enable;
      logic [7:0] noise_threshold;
      logic [10:0] carrier_period;
      logic [7:0] period_variation_limit;
      logic [7:0] ringdown_monitor_duration;
      logic [5:0] reverb_timeout;
   } cfg_t;

   typedef struct packed {
      logic [5:0] first_echo_width;
      logic [5:0] first_echo_peak;
      logic [9:0] first_echo_flight_time;
   } long_res_t;

   typedef struct packed {
      logic valid;
      logic [5:0] bits;
      logic [31:0] data;
   } frame_t;

   typedef enum logic [1:0] {
      STOP_IDLE,
      STOP_COUNT,
      STOP_RELEASE
   } stop_state_t;

endpackage

// ---- tb/ultrasonic_status_result_memory_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module ultrasonic_status_result_memory_bench
   import usrm_pkg::*;
;
   logic CLK_IN, RESET_IN, CFG_WR_IN, RD_REQ_IN, WR_REQ_IN, TX_SHIFT_IN;
   logic MEAS_START_IN, MEAS_DIRECT_IN, MEAS_END_IN, TX_ACTIVE_IN;
   logic REVERB_END_IN, ECHO_ACTIVE_IN, NOISE_WINDOW_IN, UNDERVOLT_IN;
   logic OVERVOLT_IN, TX_BIT_OUT, CMD_STB_OUT, RD_NONE_OUT, TX_STOP_OUT;
   logic MEAS_STOP_OUT, LINE_CMD_ARMED_OUT, IO_LINE_OUT, IO_LINE_OE_OUT;
   logic LINE_FAST_SLOPE_OUT, LINE_PULLUP_OUT, nr;
   wire logic IO_LINE_IN;
   logic [3:0] INDEX_IN;
   logic [5:0] ECHO_MAG_IN;
   logic [7:0] WR_DATA_IN, NOISE_MAG_IN, TEMP_CODE_IN, CMD_OUT, STATUS_OUT;
   logic [7:0] m, seed = 8'h53;
   logic [10:0] REVERB_PER_IN;
   logic [47:0] r48;
   cfg_t EEPROM_CFG_IN, CFG_IN, CFG_OUT, c;
   frame_t FRAME_OUT, fr;
   int n_fail = 0, n_compared = 0, cyc = 0, n_oe = 0, n_stop = 0, k;
   ultrasonic_status_result_memory #(.ECHO_PULSE_CYCLES(20),
      .HOST_STOP_CYCLES(40), .DEBOUNCE_CYCLES(8), .FINE_TICK_CYCLES(4)
   ) ultrasonic_status_result_memory_i (.*);
   usrm_ecu usrm_ecu_i (.clk_in(CLK_IN), .oe_in(IO_LINE_OE_OUT),
      .line_out(IO_LINE_IN));
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic rst();
      r48 = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      @(posedge CLK_IN) RESET_IN <= 1'b1;
      EEPROM_CFG_IN <= r48[45:0];
      repeat (8) @(posedge CLK_IN);
      RESET_IN <= 1'b0;
      @(posedge CLK_IN);
      #1 chk("reset", {EEPROM_CFG_IN, 8'h04}, {CFG_OUT, STATUS_OUT});
   endtask
   task automatic rd(logic [3:0] ix);
      @(posedge CLK_IN) RD_REQ_IN <= 1'b1;
      INDEX_IN <= ix;
      @(posedge CLK_IN) RD_REQ_IN <= 1'b0;
      #1 fr = FRAME_OUT;
      nr = RD_NONE_OUT;
   endtask
   task automatic wcfg();
      @(posedge CLK_IN) CFG_WR_IN <= 1'b1;
      CFG_IN <= c;
      @(posedge CLK_IN) CFG_WR_IN <= 1'b0;
      #1 chk("cfg", c, CFG_OUT);
   endtask
   task automatic go(logic d);
      @(posedge CLK_IN) MEAS_START_IN <= 1'b1;
      MEAS_DIRECT_IN <= d;
      @(posedge CLK_IN) MEAS_START_IN <= 1'b0;
   endtask
   task automatic fin();
      @(posedge CLK_IN) MEAS_END_IN <= 1'b1;
      @(posedge CLK_IN) MEAS_END_IN <= 1'b0;
   endtask
   task automatic rev(logic [10:0] p);
      @(posedge CLK_IN) REVERB_END_IN <= 1'b1;
      REVERB_PER_IN <= p;
      @(posedge CLK_IN) REVERB_END_IN <= 1'b0;
   endtask
   task automatic ser(logic [31:0] e, int n);
      chk("bit", e[0], TX_BIT_OUT);
      @(posedge CLK_IN) TX_SHIFT_IN <= 1'b1;
      for (int i = 1; i < n; i++) begin
         @(posedge CLK_IN);
         if (i == n - 1) TX_SHIFT_IN <= 1'b0;
         #1 chk("bit", e[i], TX_BIT_OUT);
      end
   endtask
   initial begin
      CLK_IN = 1'b0;
      forever #2 CLK_IN = ~CLK_IN;
   end
   always @(posedge CLK_IN) begin
      cyc++;
      n_oe += IO_LINE_OE_OUT;
      n_stop += MEAS_STOP_OUT;
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      RESET_IN = 1'b1;
      {CFG_WR_IN, RD_REQ_IN, WR_REQ_IN, TX_SHIFT_IN, MEAS_START_IN} = '0;
      {MEAS_DIRECT_IN, MEAS_END_IN, TX_ACTIVE_IN, REVERB_END_IN} = '0;
      {ECHO_ACTIVE_IN, NOISE_WINDOW_IN, UNDERVOLT_IN, OVERVOLT_IN} = '0;
      {INDEX_IN, ECHO_MAG_IN, WR_DATA_IN, NOISE_MAG_IN} = '0;
      {TEMP_CODE_IN, REVERB_PER_IN, EEPROM_CFG_IN, CFG_IN} = '0;
      rst();
      @(posedge CLK_IN) TEMP_CODE_IN <= rnd();
      rd(4'h0);
      chk("temp", {7'h10, TEMP_CODE_IN}, {fr.bits, fr.data[8:0]});
      ser({24'h0, TEMP_CODE_IN}, 8);
      @(posedge CLK_IN) WR_REQ_IN <= 1'b1;
      INDEX_IN <= 4'hF;
      WR_DATA_IN <= rnd();
      @(posedge CLK_IN) WR_REQ_IN <= 1'b0;
      #1 chk("cmd", {1'b1, WR_DATA_IN}, {CMD_STB_OUT, CMD_OUT});
      rd(4'hF);
      chk("revision", 8'h32, fr.data[7:0]);
      rd(4'h3);
      chk("no_index", 1'b1, nr);
      c = CFG_OUT;
      c.echo_pulse_mode_enable = 1'b0;
      c.advanced_io_mode_enable = 1'b0;
      c.width_peak_enable = 1'b1;
      wcfg();
      rd(4'hE);
      chk("long_off", 1'b1, nr);
      c.advanced_io_mode_enable = 1'b1;
      c.noise_threshold = 8'h40;
      c.carrier_period = 11'd100;
      c.period_variation_limit = 8'd10;
      c.ringdown_monitor_duration = 8'h00;
      c.reverb_timeout = 6'h3F;
      wcfg();
      go(1'b1);
      @(posedge CLK_IN) TX_ACTIVE_IN <= 1'b1;
      repeat (3) @(posedge CLK_IN);
      OVERVOLT_IN <= 1'b1;
      repeat (3) @(posedge CLK_IN);
      #1 chk("tx_stop", 1'b1, TX_STOP_OUT);
      @(posedge CLK_IN) TX_ACTIVE_IN <= 1'b0;
      OVERVOLT_IN <= 1'b0;
      rev(11'd115);
      m = rnd();
      @(posedge CLK_IN) ECHO_ACTIVE_IN <= 1'b1;
      ECHO_MAG_IN <= m[5:0];
      repeat (12) @(posedge CLK_IN);
      ECHO_ACTIVE_IN <= 1'b0;
      fin();
      rd(4'h1);
      chk("status", {6'd19, 11'd115, 8'h0E}, {fr.bits, fr.data[18:0]});
      ser({13'h0, 11'd115, 8'h0E}, 19);
      rd(4'hE);
      chk("peak", {6'd30, m[5:0]}, {fr.bits, fr.data[23:18]});
      chk("width", 1'b1, fr.data[29:24] inside {[2:4]});
      chk("flight", 1'b1, fr.data[17:8] <= 10'd1);
      go(1'b0);
      @(posedge CLK_IN) NOISE_WINDOW_IN <= 1'b1;
      NOISE_MAG_IN <= 8'h50;
      {TX_ACTIVE_IN, UNDERVOLT_IN} <= 2'b11;
      repeat (4) @(posedge CLK_IN);
      NOISE_WINDOW_IN <= 1'b0;
      {TX_ACTIVE_IN, UNDERVOLT_IN} <= 2'b00;
      fin();
      rd(4'hE);
      chk("idle", 30'h0F, fr.data[29:0]);
      c.echo_pulse_mode_enable = 1'b1;
      c.advanced_io_mode_enable = 1'b0;
      wcfg();
      go(1'b0);
      k = n_oe;
      for (int i = 0; i < 8; i++) begin
         @(posedge CLK_IN) ECHO_ACTIVE_IN <= (i < 2 || i > 5);
      end
      @(posedge CLK_IN) ECHO_ACTIVE_IN <= 1'b0;
      repeat (40) @(posedge CLK_IN);
      chk("merged", 20, n_oe - k);
      fin();
      go(1'b1);
      k = n_oe;
      rev(11'd100);
      repeat (30) @(posedge CLK_IN);
      chk("reverb_pulse", 20, n_oe - k);
      k = n_stop;
      usrm_ecu_i.hold(50);
      #1 chk("stop", 2'b10, {n_stop - k == 1, LINE_CMD_ARMED_OUT});
      usrm_ecu_i.rest(14);
      #1 chk("armed", 1'b1, LINE_CMD_ARMED_OUT);
      fin();
      rst();
      results();
   end
endmodule
`default_nettype wire

// ---- tb/usrm_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module usrm_chk
   import usrm_pkg::*;
#(
   parameter int ECHO_PULSE_CYCLES = 24800,
   parameter logic [3:0] FULL_MASK_REV = 4'h3,
   parameter logic [3:0] METAL_TUNE_REV = 4'h2
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   // configuration
   input wire cfg_t EEPROM_CFG_IN,
   input wire cfg_t CFG_OUT,
   // index access
   input wire logic RD_REQ_IN,
   input wire logic WR_REQ_IN,
   input wire logic [3:0] INDEX_IN,
   input wire logic [7:0] WR_DATA_IN,
   input wire logic [7:0] TEMP_CODE_IN,
   input wire frame_t FRAME_OUT,
   input wire logic RD_NONE_OUT,
   input wire logic [7:0] CMD_OUT,
   input wire logic CMD_STB_OUT,
   input wire logic [7:0] STATUS_OUT,
   // io line
   input wire logic IO_LINE_OUT,
   input wire logic IO_LINE_OE_OUT,
   input wire logic LINE_FAST_SLOPE_OUT,
   input wire logic LINE_PULLUP_OUT
);
   localparam int PL = ECHO_PULSE_CYCLES - 1;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   a_pulse_length: assert property (
      $rose(IO_LINE_OE_OUT) |-> ##PL IO_LINE_OE_OUT ##1 !IO_LINE_OE_OUT
   ) else $error("echo pulse not of fixed length");
   a_pulse_unbroken: assert property (
      $fell(IO_LINE_OE_OUT) |-> $past(IO_LINE_OE_OUT, PL)
   ) else $error("echo pulse shorter than fixed length");
   a_drives_low: assert property (
      IO_LINE_OE_OUT |-> IO_LINE_OUT == 1'b0
   ) else $error("line driven high");
   a_pulse_mode_gate: assert property (
      $rose(IO_LINE_OE_OUT) |-> $past(CFG_OUT.echo_pulse_mode_enable)
         && !$past(CFG_OUT.advanced_io_mode_enable)
   ) else $error("pulse outside echo pulse mode");
   a_reset_preload: assert property (
      $fell(RESET_IN) |-> CFG_OUT == $past(EEPROM_CFG_IN)
         && STATUS_OUT == 8'h04
   ) else $error("reset did not preload memory");
   a_line_config: assert property (
      LINE_FAST_SLOPE_OUT == CFG_OUT.line_slope_select
         && LINE_PULLUP_OUT == CFG_OUT.line_pullup_enable
   ) else $error("line slope or pull-up off config");
   a_long_refused: assert property (
      RD_REQ_IN && INDEX_IN == 4'hE && !(CFG_OUT.advanced_io_mode_enable
         && CFG_OUT.width_peak_enable) |=> RD_NONE_OUT && !FRAME_OUT.valid
   ) else $error("long result answered while disabled");
   a_revision_read: assert property (
      RD_REQ_IN && INDEX_IN == 4'hF |=> FRAME_OUT.valid
         && FRAME_OUT.data[7:0] == {FULL_MASK_REV, METAL_TUNE_REV}
   ) else $error("index 15 read wrong");
   a_cmd_taken: assert property (
      WR_REQ_IN && INDEX_IN == 4'hF |=> CMD_STB_OUT
         && CMD_OUT == $past(WR_DATA_IN)
   ) else $error("command byte not taken");
   a_temp_frame: assert property (
      RD_REQ_IN && INDEX_IN == 4'h0 |=> FRAME_OUT.bits == 6'd8
         && FRAME_OUT.data[7:0] == $past(TEMP_CODE_IN)
   ) else $error("temperature frame wrong");
endmodule
bind ultrasonic_status_result_memory usrm_chk #(
   .ECHO_PULSE_CYCLES(ECHO_PULSE_CYCLES),
   .FULL_MASK_REV(FULL_MASK_REV),
   .METAL_TUNE_REV(METAL_TUNE_REV)
) usrm_chk_i (.*);
`default_nettype wire

// ---- tb/usrm_ecu.sv ----
`timescale 1ns/100ps
`default_nettype none
module usrm_ecu (
   // clock
   input wire logic clk_in,
   // line
   input wire logic oe_in,
   output logic line_out
);
   logic low = 1'b0;
   // pull-up: a released line reads high
   assign line_out = !(oe_in || low);
   task automatic hold(int n);
      @(posedge clk_in) low <= 1'b1;
      repeat (n) @(posedge clk_in);
      low <= 1'b0;
   endtask
   task automatic rest(int n);
      repeat (n) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire
